// ---- pkg/eeprom_pkg.sv ----
// Purpose: Shared constants and types for the serial EEPROM bus slave.
// Assumes: Core clock of 125 MHz; bus lines sampled by that clock.
// Notes: The device type code default is arbitrary.
package eeprom_pkg;
    localparam int clk_mhz = 125;
    localparam int addr_w = 16;
    localparam int data_w = 8;
    // Write cycle time in milliseconds.
    localparam int write_time_ms = 5;
    // Cycles of the core clock for one write cycle.
    localparam int write_cycles = write_time_ms * 1000 * clk_mhz;
    localparam logic [addr_w-1:0] addr_reset = 16'h0000;
    localparam logic [3:0] bit_count_reset = 4'h0;
    // Position of fields inside the control byte.
    localparam int ctl_dir_pos = 0;
    localparam int ctl_sel_lsb = 1;
    localparam int ctl_type_lsb = 4;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_ctrl = 3'b001,
        st_addr_hi = 3'b011,
        st_addr_lo = 3'b010,
        st_wdata = 3'b110,
        st_rdata = 3'b111,
        st_ignore = 3'b101
    } bus_state_t;
endpackage

// ---- hw/sync2.sv ----
// Purpose: Two flip-flop synchroniser for a group of level inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module sync2 #(
    parameter int width = 1,
    parameter logic [width-1:0] reset_value = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Level in and synchronised level out.
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    typedef struct packed {
        logic [width-1:0] meta;
        logic [width-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // Shift the input through the two stages.
    always_comb begin
        s_d = s_q;
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
        if (!rstn) begin
            s_d.meta = reset_value;
            s_d.stable = reset_value;
        end
    end

    // Register the state.
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign sync_out = s_q.stable;
endmodule

// ---- hw/byte_mem.sv ----
// Purpose: Byte-wide storage array for the EEPROM contents.
// Assumes: One write port and one registered read port.
// Notes: Contents are undefined until written.
`timescale 1ns/1ps
module byte_mem #(
    parameter int addr_w = 16,
    parameter int data_w = 8
) (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic wr_en,
    input wire logic [addr_w-1:0] wr_addr,
    input wire logic [data_w-1:0] wr_data,
    // Read port, data registered.
    input wire logic [addr_w-1:0] rd_addr,
    output logic [data_w-1:0] rd_data
);
    logic [data_w-1:0] mem [0:(1<<addr_w)-1];

    // Write on request and read every cycle into the output register.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- hw/eeprom_slave.sv ----
// Purpose: Two-wire bus slave front end of a 64K x 8 serial EEPROM.
// Assumes: Bus clock and data are sampled by clk, well above bus rate.
// Notes: Only byte write and a single current address read are served.
// What this block does
// - Select only when all chip-select bits match.
// - Unconnected chip-select pins read as zero.
// - Change data only while clock low.
// - Write-protect high blocks writes, reads stay.
// - Transfers begin at any start, whatever the state.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - One bit per clock, stable while high.
// - Receiver acknowledges every byte in ninth clock.
// - Acknowledge holds data low throughout clock high.
// - No acknowledge while programming cycle runs.
// - Release data after master withholds read acknowledge.
// - First byte is type, selects, direction.
// - Direction one reads, zero writes.
// - Acknowledge control byte only on full match.
// - Two address bytes follow, high first.
// - Byte write acknowledges all, writes at stop.
// - Protected write acknowledges, stores nothing, ready.
// - Address counter points past written byte.
// - Address counter wraps inside own space.
// - Write cycle completes within five milliseconds.
// - Write-protect sampled at the stop only.
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_pkg::*;
#(
    parameter int write_cycle_count = eeprom_pkg::write_cycles,
    parameter logic [3:0] device_type = 4'h5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Serial clock input from the master.
    input wire logic scl_in,
    // Serial data, open drain: output enable pulls the line low.
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Chip-select pins and write-protect input.
    input wire logic chip_select_pin_0,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_2,
    input wire logic write_protect,
    // Status.
    output logic write_busy
);
    import eeprom_pkg::*;

    typedef struct packed {
        bus_state_t state;
        logic scl_prev;
        logic sda_prev;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic ack_phase;
        logic drive_low;
        logic read_mode;
        logic [addr_w-1:0] addr;
        logic [data_w-1:0] wr_byte;
        logic wr_pending;
        logic busy;
        logic [31:0] timer;
        logic mem_we;
    } slave_state_t;

    slave_state_t s_q;
    slave_state_t s_d;
    logic scl_s;
    logic sda_s;
    logic [2:0] cs_s;
    logic wp_s;
    logic [data_w-1:0] rd_byte;

    // Bring all pins into the clock domain. Floating pins are modelled by the
    // pad pull-downs, so an undriven level arrives here as zero.
    sync2 #(.width(6), .reset_value(6'h03)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({write_protect, chip_select_pin_2, chip_select_pin_1, chip_select_pin_0, sda_in, scl_in}),
        .sync_out({wp_s, cs_s, sda_s, scl_s})
    );

    byte_mem #(.addr_w(addr_w), .data_w(data_w)) u_mem (
        .clk(clk),
        .wr_en(s_q.mem_we),
        .wr_addr(s_q.addr),
        .wr_data(s_q.wr_byte),
        .rd_addr(s_q.addr),
        .rd_data(rd_byte)
    );

    // Control byte match against type code and chip-select pins.
    function automatic logic ctl_match(input logic [7:0] b, input logic [2:0] cs, input logic [3:0] dt);
        ctl_match = (b[7:ctl_type_lsb] == dt) && (b[ctl_sel_lsb+2:ctl_sel_lsb] == cs);
    endfunction

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    assign start_cond = s_q.scl_prev && scl_s && s_q.sda_prev && !sda_s;
    assign stop_cond = s_q.scl_prev && scl_s && !s_q.sda_prev && sda_s;
    assign scl_rise = !s_q.scl_prev && scl_s;
    assign scl_fall = s_q.scl_prev && !scl_s;

    // Bus protocol engine and write cycle timer.
    always_comb begin
        logic [7:0] nb;
        nb = {s_q.shift[6:0], sda_s};
        s_d = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.mem_we = 1'b0;
        // Programming cycle timing.
        if (s_q.busy) begin
            if (s_q.timer == 32'h0) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.timer = s_q.timer - 32'h1;
            end
        end
        if (start_cond) begin
            // A start is honoured from any state; idle is the usual origin.
            s_d.state = st_ctrl;
            s_d.bit_cnt = bit_count_reset;
            s_d.ack_phase = 1'b0;
            s_d.drive_low = 1'b0;
            s_d.wr_pending = 1'b0;
        end else if (stop_cond) begin
            s_d.state = st_idle;
            s_d.drive_low = 1'b0;
            // Protect level is taken at the stop and never looked at again.
            if (s_q.wr_pending && !wp_s) begin
                s_d.mem_we = 1'b1;
                s_d.busy = 1'b1;
                s_d.timer = 32'(write_cycle_count - 1);
            end
            s_d.wr_pending = 1'b0;
        end else if (s_q.state != st_idle && s_q.state != st_ignore) begin
            if (scl_rise && !s_q.ack_phase) begin
                // Sample a data bit on the rising clock edge.
                s_d.shift = nb;
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end else if (scl_rise && s_q.ack_phase && s_q.read_mode && s_q.state == st_rdata) begin
                // Master acknowledge or not; this block serves one byte then releases.
                s_d.state = st_ignore;
            end else if (scl_fall && s_q.ack_phase) begin
                // End of the ninth clock: leave the acknowledge slot.
                s_d.ack_phase = 1'b0;
                s_d.drive_low = 1'b0;
                s_d.bit_cnt = bit_count_reset;
                // Only a read control byte is still in st_ctrl here; its slot ends and the data byte begins.
                if (s_q.state == st_ctrl) begin
                    s_d.state = st_rdata;
                    s_d.shift = rd_byte;
                    s_d.drive_low = !rd_byte[7];
                    s_d.addr = s_q.addr + 16'h0001;
                end
            end else if (scl_fall && s_q.bit_cnt == 4'h8) begin
                // Eight bits in: decide the acknowledge, driven in the ninth clock.
                s_d.ack_phase = 1'b1;
                case (s_q.state)
                    st_ctrl: begin
                        if (ctl_match(s_q.shift, cs_s, device_type) && !s_q.busy) begin
                            s_d.drive_low = 1'b1;
                            s_d.read_mode = s_q.shift[ctl_dir_pos];
                            // A read stays in st_ctrl through its acknowledge so that slot is not taken as the
                            // master's answer to a data byte.
                            s_d.state = s_q.shift[ctl_dir_pos] ? st_ctrl : st_addr_hi;
                        end else begin
                            s_d.state = st_ignore;
                            s_d.ack_phase = 1'b0;
                        end
                    end
                    st_addr_hi: begin
                        s_d.addr = {s_q.shift, s_q.addr[7:0]};
                        s_d.drive_low = 1'b1;
                        s_d.state = st_addr_lo;
                    end
                    st_addr_lo: begin
                        s_d.addr = {s_q.addr[15:8], s_q.shift};
                        s_d.drive_low = 1'b1;
                        s_d.state = st_wdata;
                    end
                    st_wdata: begin
                        // Every data byte is acknowledged even when protected.
                        s_d.wr_byte = s_q.shift;
                        s_d.wr_pending = 1'b1;
                        s_d.drive_low = 1'b1;
                    end
                    st_rdata: begin
                        // Byte sent; release and wait for the master's answer.
                        s_d.drive_low = 1'b0;
                    end
                    default: begin
                        s_d.state = st_ignore;
                    end
                endcase
            end else if (scl_fall && s_q.state == st_rdata && !s_q.ack_phase) begin
                // The rising edge already moved the register on, so the next bit to send is the top bit.
                s_d.drive_low = !s_q.shift[7];
            end
        end
        // The written byte's successor becomes the current address.
        if (s_q.mem_we) begin
            s_d.addr = s_q.addr + 16'h0001;
        end
        if (!rstn) begin
            s_d = '0;
            s_d.state = st_idle;
            s_d.scl_prev = 1'b1;
            s_d.sda_prev = 1'b1;
            s_d.addr = addr_reset;
        end
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // Open-drain drive: only ever pull low.
    assign sda_out = 1'b0;
    assign sda_oe = s_q.drive_low;
    assign write_busy = s_q.busy;
endmodule

// ---- testbench/eeprom_slave_props.sv ----
// Purpose: Port checker for the EEPROM bus slave.
// Assumes: Pins are seen raw, ahead of the slave's synchronisers.
// Notes: Bound to every slave instance.
`timescale 1ns/1ps
module eeprom_slave_props #(
    parameter int write_cycle_count = 50
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Bus lines and control.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic write_busy
);
    int busy_cnt_q;
    int since_stop_q;
    logic wp_stop_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Counts busy cycles and cycles since a stop, and keeps write-protect at that stop.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_cnt_q <= 0;
            since_stop_q <= 255;
            wp_stop_q <= 1'b0;
        end else begin
            busy_cnt_q <= write_busy ? busy_cnt_q + 1 : 0;
            if (scl_in && $past(scl_in) && sda_in && !$past(sda_in)) begin
                since_stop_q <= 0;
                wp_stop_q <= write_protect;
            end else if (since_stop_q < 255) begin
                since_stop_q <= since_stop_q + 1;
            end
        end
    end
    sequence start_s;
        scl_in && $fell(sda_in);
    endsequence
    sequence stop_s;
        scl_in && $rose(sda_in);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !sda_oe && !write_busy)
        else $error("outputs active after reset");
    a_drive_low_only: assert property (sda_out == 1'b0) else $error("data driven high");
    a_no_ack_busy: assert property (write_busy |-> !sda_oe) else $error("ack while busy");
    a_busy_length: assert property ($fell(write_busy) |-> busy_cnt_q == write_cycle_count)
        else $error("write cycle length wrong");
    a_busy_at_stop: assert property ($rose(write_busy) |-> since_stop_q <= 8 && !wp_stop_q)
        else $error("write cycle without stop");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
    a_ack_holds: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*8]) else $error("low not held");
    a_start_quiet: assert property (start_s |-> !sda_oe [*8]) else $error("drive after start");
    a_stop_release: assert property (stop_s |-> !sda_oe [*8]) else $error("drive after stop");
endmodule
bind eeprom_slave eeprom_slave_props #(.write_cycle_count(write_cycle_count)) u_props (
    .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect), .write_busy(write_busy));

// ---- testbench/bus_master.sv ----
// Purpose: Two-wire bus master model driving clock and data.
// Assumes: Data line has a pull-up, so a released line reads high.
// Notes: One bit takes 20 core clocks, a 160 ns bus clock.
`timescale 1ns/1ps
module bus_master (
    // Core clock for timing.
    input wire logic clk,
    // Resolved data line and driven lines.
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    // Idle bus has both lines high.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic q();
        repeat (5) @(negedge clk);
    endtask
    // Only this model clocks the bus and frames it.
    task automatic start();
        sda_drv = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    // Data rises while the clock is high.
    task automatic stop();
        sda_drv = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_drv = 1'b1;
        q();
        q();
    endtask
    // One bit per pulse, changed only while the clock is low.
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        q();
        scl = 1'b1;
        q();
        r = sda_line;
        q();
        scl = 1'b0;
        q();
    endtask
    // Ninth pulse gives the slave its acknowledge slot.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    // The only byte of a read is left unacknowledged.
    task automatic recv_byte(output logic [7:0] b, output logic rel);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(1'b1, rel);
    endtask
endmodule

// ---- testbench/tb_eeprom_slave.sv ----
// Purpose: Self-checking bench for the EEPROM bus slave.
// Assumes: Write cycle shortened to 400 clocks.
// Notes: A byte map and a pointer model the array.
`timescale 1ns/1ps
module tb_eeprom_slave;
    localparam logic [3:0] dev_type = 4'h9; // Arbitrary type code.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] pins = 3'h0;
    logic wp = 1'b0;
    logic scl, sda_drv, sda_out, sda_oe, busy, ack;
    wire logic sda_line = sda_drv & (~sda_oe | sda_out);
    int n_fail = 0;
    int samples_checked = 0;
    int ptr = 0;
    logic [31:0] seed = 32'd29;
    logic [7:0] mem [int];
    logic [7:0] d0, d1, d;
    logic [15:0] a;
    eeprom_slave #(.write_cycle_count(400), .device_type(dev_type)) u_eeprom_slave (
        .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_pin_0(pins[0]), .chip_select_pin_1(pins[1]), .chip_select_pin_2(pins[2]),
        .write_protect(wp), .write_busy(busy));
    bus_master u_bus_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    always #4 clk = ~clk;
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic ctrl(input logic [3:0] typ, input logic [2:0] sel, input logic dir, output logic ok);
        u_bus_master.start();
        u_bus_master.send_byte({typ, sel, dir}, ok);
    endtask
    // Byte write; the model stores only when unprotected.
    task automatic write_byte(input logic [15:0] wa, input logic [7:0] v);
        logic k0, k1, k2, k3;
        ctrl(dev_type, pins, 1'b0, k0);
        u_bus_master.send_byte(wa[15:8], k1);
        u_bus_master.send_byte(wa[7:0], k2);
        u_bus_master.send_byte(v, k3);
        u_bus_master.stop();
        check({4'h0, k0, k1, k2, k3}, 8'h0f);
        if (!wp) begin
            mem[wa] = v;
            ptr = (int'(wa) + 1) % 65536;
        end
        repeat (8) @(negedge clk);
        check({7'h0, busy}, {7'h0, !wp});
    endtask
    // Optional address load and restart, then a one-byte read.
    task automatic read_check(input logic set, input logic [15:0] ra);
        logic k, rel;
        logic [7:0] v;
        if (set) begin
            ctrl(dev_type, pins, 1'b0, k);
            u_bus_master.send_byte(ra[15:8], k);
            u_bus_master.send_byte(ra[7:0], k);
            ptr = ra;
        end
        ctrl(dev_type, pins, 1'b1, k);
        u_bus_master.recv_byte(v, rel);
        u_bus_master.stop();
        check(v, mem[ptr]);
        check({7'h0, rel}, 8'h01);
        ptr = (ptr + 1) % 65536;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(negedge clk);
        check({7'h0, busy}, 8'h00);
    endtask
    // Main sequence: selection, writes, protection, random traffic.
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            pins = k[2:0];
            repeat (4) @(negedge clk);
            d = xs();
            ctrl(dev_type, k[2:0], 1'b0, ack);
            check({7'h0, ack}, 8'h01);
            ctrl(dev_type, k[2:0] ^ (3'h1 << (k % 3)), d[0], ack);
            check({7'h0, ack}, 8'h00);
            u_bus_master.send_byte({dev_type, k[2:0], 1'b0}, ack);
            check({7'h0, ack}, 8'h00);
            ctrl(~dev_type, k[2:0], 1'b0, ack);
            check({7'h0, ack}, 8'h00);
            u_bus_master.stop();
        end
        d = xs();
        pins = d[2:0];
        d0 = xs();
        d1 = xs();
        write_byte(16'h0000, d0);
        ctrl(dev_type, pins, 1'b0, ack);
        u_bus_master.stop();
        check({7'h0, ack}, 8'h00);
        wait_idle();
        write_byte(16'hffff, d1);
        repeat (10) @(negedge clk);
        wp = 1'b1;
        wait_idle();
        read_check(1'b0, 16'h0000);
        write_byte(16'h0000, ~d0);
        ctrl(dev_type, pins, 1'b0, ack);
        check({7'h0, ack}, 8'h01);
        read_check(1'b1, 16'h0000);
        read_check(1'b1, 16'hffff);
        wp = 1'b0;
        for (int i = 0; i < 3; i++) begin
            d = xs();
            a = {xs(), xs()};
            write_byte(a, d);
            wait_idle();
            read_check(1'b1, a);
        end
        end_of_test();
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule
